// [ltcap_pin_model.sv]
`timescale 1ns/1ns
// Far-side source on the capture pin; either edge is an event, so a request just flips it.
module ltcap_pin_model (
	// Clock, reset and request.
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic flip_i,
	// Pin level seen by the timer.
	output logic      capture_pin_o
);
	// The level moves just after an edge, so the timer sees one clean change.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			capture_pin_o <= 1'b0;
		else if (flip_i)
			capture_pin_o <= ~capture_pin_o;
	end
endmodule : ltcap_pin_model

// [ltcap_pkg.sv]
package ltcap_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_TB2_CS   = 6'h08;
	localparam logic [5:0] IDX_RELOAD   = 6'h09;
	localparam logic [5:0] IDX_CNT2     = 6'h0A;
	localparam logic [5:0] IDX_TB1_CS   = 6'h0B;
	localparam logic [5:0] IDX_CAPTURE  = 6'h0C;
	// Field positions in the two control/status registers.
	localparam int TB2_OVERFLOW_FLAG_BIT  = 0;
	localparam int TB2_IRQ_ENABLE_BIT = 1;
	localparam int TB1_OVERFLOW_FLAG_BIT  = 3;
	localparam int TB1_IRQ_ENABLE_BIT = 4;
	localparam int PSEL_BIT  = 5;
	localparam int CAPF_BIT  = 6;
	localparam int CAPIE_BIT = 7;
	// Reset values.
	localparam logic [7:0] RELOAD_RST  = 8'h00;
	localparam logic [7:0] CNT1_RST    = 8'h00;
	localparam logic [7:0] CNT2_RST    = 8'h00;
	localparam logic [7:0] CAPTURE_RST = 8'h00;
	localparam logic       CTRL_RST    = 1'b0;
	// Counting constants, in oscillator periods and counter codes.
	localparam int         PRESCALE_DIV = 32;
	localparam logic [7:0] CNT1_LAST    = 8'hF9;
	localparam logic [7:0] CNT2_LAST    = 8'hFF;
endpackage : ltcap_pkg

// [ltcap_timer.sv]
`timescale 1ns/1ns
module ltcap_timer #(
	parameter int PRESCALE = ltcap_pkg::PRESCALE_DIV
) (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Classic Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Capture pin and power mode state.
	input  wire logic        capture_pin_i,
	input  wire logic        halt_i,
	input  wire logic        active_halt_i,
	input  wire logic        wait_i,
	input  wire logic        slow_i,
	input  wire logic        cpu_imask_i,
	// Interrupt requests and wake-up.
	output logic             irq_tb1_o,
	output logic             irq_tb2_o,
	output logic             irq_cap_o,
	output logic             wake_o
);
	import ltcap_pkg::*;

	localparam int PW = $clog2(PRESCALE);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

	// Index compare used by every register select.
	function automatic logic idx_is(input logic [5:0] idx, input logic [5:0] want);
		idx_is = (idx == want);
	endfunction : idx_is

	logic [1:0]    rst_sync;
	logic          rst_n;
	logic [PW-1:0] pre_cnt;
	logic [7:0]    cnt1;
	logic          half;
	logic [7:0]    cnt2;
	logic [7:0]    reload;
	logic [7:0]    capture;
	logic          pin_prev;
	logic          tb2_ie;
	logic          tb2_flag;
	logic          tb1_ie;
	logic          tb1_flag;
	logic          psel;
	logic          cap_ie;
	logic          cap_flag;

	// Reset is released through two flops so every register leaves reset together.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// Bus decode; an access is taken in the cycle before ack rises.
	wire       acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       rd      = acc & ~wb_we_i;
	wire       wr      = acc & wb_we_i & wb_sel_i[0];
	wire [5:0] idx     = wb_adr_i[7:2];
	wire       rd_tb2  = rd & idx_is(idx, IDX_TB2_CS);
	wire       rd_tb1  = rd & idx_is(idx, IDX_TB1_CS);
	wire       rd_cap  = rd & idx_is(idx, IDX_CAPTURE);
	wire       wr_tb2  = wr & idx_is(idx, IDX_TB2_CS);
	wire       wr_tb1  = wr & idx_is(idx, IDX_TB1_CS);
	wire       wr_rld  = wr & idx_is(idx, IDX_RELOAD);

	// Halt alone gates the shared tick; slow, wait and active-halt are not looked at
	// because the timer runs from the divided oscillator, not the CPU clock.
	wire run      = ~halt_i;
	wire tick     = run & (pre_cnt == PRE_LAST);
	wire cnt1_wrap = tick & (cnt1 == CNT1_LAST);
	wire tb1_evt  = cnt1_wrap & (~psel | half);
	wire cnt2_ovf = tick & (cnt2 == CNT2_LAST);
	wire pin_edge = capture_pin_i ^ pin_prev;
	wire cap_evt  = pin_edge & ~cap_flag;

	// Next values; a hardware set is ordered after the read clear so it wins.
	wire next_tb2_flag = cnt2_ovf | (tb2_flag & ~rd_tb2);
	wire next_tb1_flag = tb1_evt | (tb1_flag & ~rd_tb1);
	wire next_cap_flag = cap_evt | (cap_flag & ~rd_cap);
	wire [7:0] next_cnt2 = cnt2_ovf ? reload : 8'(cnt2 + 8'h01);

	// Status readback; reserved bits read zero.
	wire [7:0] tb2_cs = {6'h00, tb2_ie, tb2_flag};
	wire [7:0] tb1_cs = {cap_ie, cap_flag, psel, tb1_ie, tb1_flag, 3'b000};
	wire [7:0] rd_mux = idx_is(idx, IDX_TB2_CS)  ? tb2_cs :
	                    idx_is(idx, IDX_RELOAD)  ? reload :
	                    idx_is(idx, IDX_CNT2)    ? cnt2 :
	                    idx_is(idx, IDX_TB1_CS)  ? tb1_cs :
	                    idx_is(idx, IDX_CAPTURE) ? capture : 8'h00;

	// Single-wait-state slave: ack one cycle after the request, dropped the next.
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= acc;
			if (rd)
				wb_dat_o <= {24'h00_0000, rd_mux};
		end
	end

	// Prescaler and counter 1; counter 1 has no bus access at all.
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt <= '0;
			cnt1    <= CNT1_RST;
			half    <= 1'b0;
		end
		else if (run)
		begin
			pre_cnt <= tick ? '0 : PW'(pre_cnt + 1'b1);
			if (cnt1_wrap)
			begin
				cnt1 <= 8'h00;
				half <= ~half;
			end
			else if (tick)
				cnt1 <= 8'(cnt1 + 8'h01);
		end
	end

	// Counter 2 and its reload register; writes to the counter itself are dropped.
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt2   <= CNT2_RST;
			reload <= RELOAD_RST;
		end
		else
		begin
			if (tick)
				cnt2 <= next_cnt2;
			if (wr_rld)
				reload <= wb_dat_i[7:0];
		end
	end

	// Capture path. The flag resets clear here, but software still reads the
	// capture register once after reset as the portable way to be sure of it.
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_prev <= 1'b0;
			capture  <= CAPTURE_RST;
			cap_flag <= CTRL_RST;
		end
		else
		begin
			pin_prev <= capture_pin_i;
			if (cap_evt)
				capture <= cnt1;
			cap_flag <= next_cap_flag;
		end
	end

	// Control bits and overflow flags; flag bits ignore bus writes.
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tb2_ie   <= CTRL_RST;
			tb2_flag <= CTRL_RST;
			tb1_ie   <= CTRL_RST;
			tb1_flag <= CTRL_RST;
			psel     <= CTRL_RST;
			cap_ie   <= CTRL_RST;
		end
		else
		begin
			tb2_flag <= next_tb2_flag;
			tb1_flag <= next_tb1_flag;
			if (wr_tb2)
				tb2_ie <= wb_dat_i[TB2_IRQ_ENABLE_BIT];
			if (wr_tb1)
			begin
				cap_ie <= wb_dat_i[CAPIE_BIT];
				psel   <= wb_dat_i[PSEL_BIT];
				tb1_ie <= wb_dat_i[TB1_IRQ_ENABLE_BIT];
			end
		end
	end

	// Three separate requests, each gated by its enable and the CPU mask.
	assign irq_tb1_o = tb1_flag & tb1_ie & ~cpu_imask_i;
	assign irq_tb2_o = tb2_flag & tb2_ie & ~cpu_imask_i;
	assign irq_cap_o = cap_flag & cap_ie & ~cpu_imask_i;

	// Wait accepts any request; active-halt only the timebase-1 one; halt none.
	assign wake_o = (wait_i & (irq_tb1_o | irq_tb2_o | irq_cap_o)) |
	                (active_halt_i & ~halt_i & irq_tb1_o);

	// Checks.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	logic past_valid;
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
			past_valid <= 1'b0;
		else
			past_valid <= 1'b1;
	end

	AST_HALT_FREEZE: assert property (halt_i |=> $stable(cnt2) && $stable(cnt1))
		else $error("Counters moved during halt.");
	AST_RUN_ANY_MODE: assert property ((tick && cnt2 != CNT2_LAST)
		|=> cnt2 == 8'($past(cnt2) + 8'h01))
		else $error("Counter 2 failed to advance.");
	AST_TB2_WAKE: assert property ((wait_i && irq_tb2_o) |-> wake_o)
		else $error("Timebase-2 request did not wake from wait.");
	AST_NO_WAKE: assert property ((!wait_i && !irq_tb1_o) |-> !wake_o)
		else $error("Wake raised outside wait without timebase 1.");
	AST_IRQ_TB2: assert property (irq_tb2_o == (tb2_flag && tb2_ie && !cpu_imask_i))
		else $error("Timebase-2 request mismatch.");
	AST_MASK: assert property (cpu_imask_i |-> !(irq_tb1_o || irq_tb2_o || irq_cap_o))
		else $error("Request while CPU mask set.");
	AST_RELOAD: assert property (cnt2_ovf |=> cnt2 == $past(reload) && tb2_flag)
		else $error("Counter 2 did not reload on overflow.");
	AST_TB2_OVERFLOW_FLAG_CLEAR: assert property ((rd_tb2 && !cnt2_ovf) |=> !tb2_flag)
		else $error("Timebase-2 flag not cleared by read.");
	AST_CAP_HOLD: assert property ((cap_flag && !rd_cap) |=> $stable(capture) && cap_flag)
		else $error("Capture changed while flag set.");
	AST_CNT1_WRAP: assert property (cnt1_wrap |=> cnt1 == 8'h00)
		else $error("Counter 1 did not wrap to zero.");
	AST_DOUBLE: assert property ((cnt1_wrap && psel && !half && !tb1_flag && !rd_tb1)
		|=> !tb1_flag)
		else $error("Timebase-1 event on odd wrap with period select.");
	AST_SET_WINS: assert property ((tb1_evt && rd_tb1) |=> tb1_flag)
		else $error("Timebase-1 event lost against read.");
	AST_ACK_PULSE: assert property (past_valid && wb_ack_o |=> !wb_ack_o)
		else $error("Ack held for more than one cycle.");
	AST_ACK_ONE: assert property (acc |=> wb_ack_o)
		else $error("Taken request was not acknowledged.");

	// Flag clears, a bus write and the capture latch; each one guards a different way a flag or the capture could go wrong.
	AST_TB1_OVERFLOW_FLAG_CLEAR: assert property ((rd_tb1 && !tb1_evt) |=> !tb1_flag)
		else $error("Timebase-1 flag not cleared by read.");
	AST_CAPF_CLEAR: assert property ((rd_cap && !cap_evt) |=> !cap_flag)
		else $error("Capture flag not cleared by capture read.");
	AST_TB2_OVERFLOW_FLAG_WRITE: assert property ((wr_tb2 && !cnt2_ovf && !tb2_flag) |=> !tb2_flag)
		else $error("Bus write set the timebase-2 flag.");
	AST_CAP_LATCH: assert property (cap_evt |=> capture == $past(cnt1) && cap_flag)
		else $error("Capture did not latch counter 1.");

	// Counter 1 stepping and the short period; a stuck prescaler shows up here first.
	AST_CNT1_STEP: assert property ((tick && !cnt1_wrap)
		|=> cnt1 == 8'($past(cnt1) + 8'h01))
		else $error("Counter 1 failed to advance.");
	AST_SHORT_PERIOD: assert property ((cnt1_wrap && !psel && !rd_tb1) |=> tb1_flag)
		else $error("Timebase-1 event missing with short period.");

	// Request lines and wake-up; halt must never be left by these requests.
	AST_IRQ_TB1: assert property (irq_tb1_o == (tb1_flag && tb1_ie && !cpu_imask_i))
		else $error("Timebase-1 request mismatch.");
	AST_IRQ_CAP: assert property (irq_cap_o == (cap_flag && cap_ie && !cpu_imask_i))
		else $error("Capture request mismatch.");
	AST_HALT_NO_WAKE: assert property ((halt_i && !wait_i) |-> !wake_o)
		else $error("Wake raised in halt mode.");

	COV_TB2_OVF: cover property (cnt2_ovf ##1 irq_tb2_o);
	COV_CAPTURE: cover property (cap_evt ##[1:50] rd_cap);
	COV_TB1_LONG: cover property (psel && tb1_evt);
	COV_WAKE: cover property (wait_i && wake_o);
	COV_HALT_RESUME: cover property (halt_i ##1 !halt_i);
endmodule : ltcap_timer

// [ltcap_timer_tb.sv]
`timescale 1ns/1ns
module ltcap_timer_tb;
	import ltcap_pkg::*;
	logic        mclk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, flip = 1'b0;
	logic        halt = 1'b0, ahalt = 1'b0, wt = 1'b0, imask = 1'b0;
	logic [7:0]  adr = 8'h00, rd;
	logic [31:0] wdat = 32'h0, dat;
	logic        ack, pin, irq1, irq2, irqc, wake;
	wire  [3:0]  ev = {wake, irqc, irq2, irq1};
	int          bad_count = 0, total_checks = 0, n;
	// A short prescaler keeps the timebase waits to a few thousand cycles.
	always #4 mclk_i = ~mclk_i;
	ltcap_timer #(.PRESCALE(4)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(dat), .wb_ack_o(ack), .capture_pin_i(pin), .halt_i(halt),
		.active_halt_i(ahalt), .wait_i(wt), .slow_i(1'b0), .cpu_imask_i(imask),
		.irq_tb1_o(irq1), .irq_tb2_o(irq2), .irq_cap_o(irqc), .wake_o(wake));
	ltcap_pin_model pm (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .flip_i(flip), .capture_pin_o(pin));
	// Verdict and end of run.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// One classic cycle; the request holds until ack is sampled high.
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int i;
		cyc <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
		i = 0;
		do
		begin
			@(posedge mclk_i);
			i++;
		end
		while (ack !== 1'b1 && i < 50);
		rd = dat[7:0];
		cyc <= 1'b0; we <= 1'b0;
		if (i >= 50)
		begin
			bad_count++;
			tally_and_finish();
		end
		@(posedge mclk_i);
	endtask : bus
	// Counts edges until an event line is high; running out ends the run.
	task automatic wait_hi(input int k, input int lim, output int c);
		c = 0;
		do
		begin
			@(posedge mclk_i);
			c++;
		end
		while (ev[k] !== 1'b1 && c < lim);
		if (ev[k] !== 1'b1)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask : wait_hi
	initial
	begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		bus(0, IDX_CAPTURE, 0); check("cap_rst", rd, CAPTURE_RST);
		bus(0, IDX_TB1_CS, 0); check("cs1_rst", rd, 8'h00);
		bus(0, 6'h3F, 0); check("unmapped", rd, 8'h00);
		bus(0, IDX_RELOAD, 0); check("rel_rst", rd, RELOAD_RST);
		bus(1, IDX_RELOAD, 8'hF0); bus(0, IDX_RELOAD, 0); check("reload", rd, 8'hF0);
		bus(1, IDX_TB2_CS, 8'h03);
		bus(0, IDX_TB2_CS, 0); check("cs2", rd, 8'h02);
		bus(1, IDX_CNT2, 8'h00); bus(0, IDX_CNT2, 0); check("cnt2_ro", 8'(rd != 0), 1);
		bus(1, IDX_TB1_CS, 8'hFF); bus(0, IDX_TB1_CS, 0); check("cs1", rd, 8'hB0);
		$display("test registers done");
		// Counter 2 overflows while the CPU mask holds every request down.
		imask <= 1'b1;
		repeat (1100) @(posedge mclk_i);
		check("masked", 8'(irq2), 0);
		imask <= 1'b0;
		repeat (2) @(posedge mclk_i);
		check("irq2", 8'(irq2), 1);
		check("irq1", 8'(irq1), 0);
		wt <= 1'b1;
		repeat (2) @(posedge mclk_i);
		check("wake_w", 8'(wake), 1);
		wt <= 1'b0; ahalt <= 1'b1;
		repeat (2) @(posedge mclk_i);
		check("wake_ah", 8'(wake), 0);
		ahalt <= 1'b0;
		bus(0, IDX_TB2_CS, 0); check("f2", rd, 8'h03);
		bus(0, IDX_TB2_CS, 0); check("f2_clr", rd, 8'h02);
		wait_hi(1, 200, n); check("reload_per", 8'(n <= 64), 1);
		bus(0, IDX_CNT2, 0); check("cnt2", 8'(rd >= 8'hF0), 1);
		bus(0, IDX_TB2_CS, 0);
		halt <= 1'b1;
		repeat (300) @(posedge mclk_i);
		check("halt", 8'(irq2), 0);
		halt <= 1'b0;
		wait_hi(1, 100, n); check("resume", 8'(irq2), 1);
		bus(1, IDX_TB2_CS, 8'h00);
		$display("test counter2 done");
		// Timebase 1 period for both settings of the period select.
		for (int p = 1; p >= 0; p--)
		begin
			bus(1, IDX_TB1_CS, {2'b10, p[0], 5'h10});
			wait_hi(0, 3000, n);
			bus(0, IDX_TB1_CS, 0); check("f1", rd, {2'b10, p[0], 5'h18});
			wait_hi(0, 2100, n);
			check("tb1_per", 8'(n >= 1000 * (p + 1) - 10 && n <= 1000 * (p + 1)), 1);
			bus(0, IDX_TB1_CS, 0);
		end
		$display("test timebase1 done");
		// Capture sets the flag; writes and status reads leave it, a capture read clears it.
		flip <= 1'b1;
		@(posedge mclk_i);
		flip <= 1'b0;
		wait_hi(2, 10, n); check("irqc", 8'(irqc), 1);
		bus(1, IDX_TB1_CS, 8'h80); bus(0, IDX_TB1_CS, 0); check("capf", rd & 8'hC0, 8'hC0);
		bus(0, IDX_CAPTURE, 0); bus(0, IDX_TB1_CS, 0); check("capf_clr", rd & 8'hC0, 8'h80);
		check("irqc_clr", 8'(irqc), 0);
		$display("test capture done");
		tally_and_finish();
	end
endmodule : ltcap_timer_tb
